// >>> lmd_pkg.sv
// Shared constants and types of the LED multiplex driver slave
// Assumes a single 50 MHz core clock and an active-low power-on reset
package lmd_pkg;

  // Core clock
  localparam int CLK_PERIOD_NS = 20;

  // Slave address: write address is this value shifted left by one
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h38;

  // Subaddresses
  localparam logic [2:0] SUB_CONTROL = 3'h0;
  localparam logic [2:0] SUB_DIGIT_ONE = 3'h1;
  localparam logic [2:0] SUB_DIGIT_TWO = 3'h2;
  localparam logic [2:0] SUB_DIGIT_THREE = 3'h3;
  localparam logic [2:0] SUB_DIGIT_FOUR = 3'h4;
  localparam int REG_COUNT = 5;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b1;

  // Status byte layout
  localparam int STATUS_FLAG_BIT = 7;

  // Bit counter value of the acknowledge slot
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Multiplex half period
  localparam int MUX_HALF_PERIOD_NS = 2560;
  localparam int MUX_HALF_CYCLES = MUX_HALF_PERIOD_NS / CLK_PERIOD_NS;

  // Control register fields, bit 0 first from the right
  typedef struct packed {
    logic reserved;
    logic current_step_large;
    logic current_step_mid;
    logic current_step_small;
    logic segment_test_bit;
    logic blank_pair_even;
    logic blank_pair_odd;
    logic mux_mode_bit;
  } lmd_ctrl_s;

  // Display drive bundle
  typedef struct packed {
    logic mux_drive_first;
    logic mux_drive_second;
    logic [15:0] segments;
  } lmd_drive_s;

  // Serial slave states
  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_INSTR,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } lmd_state_e;

endpackage

// >>> lmd_mux_timer.sv
// Multiplex oscillator model: divider that toggles the display phase
// Assumes a run level from the same clock domain
`timescale 1ns/1ns
module lmd_mux_timer
  import lmd_pkg::*;
#(
  parameter int HALF_CYCLES = MUX_HALF_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Control
  input wire logic i_run,
  // Phase
  output logic o_phase
);

  localparam int CW = $clog2(HALF_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

  logic [CW-1:0] count;
  wire at_last = (count == LAST);

  // Stopped divider holds phase and count at zero
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count <= '0;
      o_phase <= 1'b0;
    end else if (!i_run) begin
      count <= '0;
      o_phase <= 1'b0;
    end else if (at_last) begin
      count <= '0;
      o_phase <= ~o_phase;
    end else begin
      count <= count + CW'(1);
    end
  end

endmodule

// >>> lmd_led_driver.sv
// Four-digit LED multiplex driver behind a two-wire serial slave port
// Assumes SCL, SDA and the address select come from outside the clock
// domain; SDA is open drain and the board resolves the wire level.
//
// Contract
// - Answer write address 70..76 hex and read 71..77 hex by select pins
// - Acknowledge no slave address other than the selected pair
// - Reads return status byte holding only the power-fail flag
// - Clear the power-fail flag once a status read completes
// - Instruction byte pointer bits choose the first written register
// - Further data bytes go to consecutive subaddresses
// - Pointer wraps from 7 back to 0
// - Subaddress 0 is control, 1 to 4 digits, 5 to 7 unused
// - Mode 1 alternates digit pairs; mode 0 shows digits 1 and 2
// - Blank bits blank digits 1+3 or 2+4 when 0
// - Segment test bit switches every segment output on
// - Three current bits add 3, 6 and 12 mA steps
// - Segment on when its data bit is 1, eight bits per digit
// - Data MSB drives sink 8 or 16, LSB sink 1 or 9
// - Bytes latch on the rising SCL edge of the acknowledge bit
// - Reset clears all registers and sets only the power-fail flag
// - Static mode stops the multiplex oscillator
// - Dynamic mode toggles the multiplex drives from the oscillator
// - Static mode holds first multiplex drive on, second off
`timescale 1ns/1ns
module lmd_led_driver
  import lmd_pkg::*;
#(
  parameter int MUX_HALF = MUX_HALF_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Serial bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Address select level, quantised to two bits
  input wire logic [1:0] i_addr_sel,
  // Display drive
  output logic [15:0] o_segment_sink,
  output logic o_mux_drive_first,
  output logic o_mux_drive_second,
  // Current steps: small, mid, large
  output logic [2:0] o_current_step,
  output logic o_mux_osc_run
);

  // Synchronisers
  logic scl_q1, scl_q2, scl_q3;
  logic sda_q1, sda_q2, sda_q3;
  logic [1:0] sel_q1, sel_q2;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_q1 <= 1'b1;
      scl_q2 <= 1'b1;
      scl_q3 <= 1'b1;
      sda_q1 <= 1'b1;
      sda_q2 <= 1'b1;
      sda_q3 <= 1'b1;
    end else begin
      scl_q1 <= i_scl;
      scl_q2 <= scl_q1;
      scl_q3 <= scl_q2;
      sda_q1 <= i_sda;
      sda_q2 <= sda_q1;
      sda_q3 <= sda_q2;
    end
  end

  // Address select level
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sel_q1 <= 2'h0;
      sel_q2 <= 2'h0;
    end else begin
      sel_q1 <= i_addr_sel;
      sel_q2 <= sel_q1;
    end
  end

  // Bus events
  wire scl_rise = scl_q2 & ~scl_q3;
  wire scl_fall = ~scl_q2 & scl_q3;
  wire bus_start = scl_q2 & scl_q3 & sda_q3 & ~sda_q2;
  wire bus_stop = scl_q2 & scl_q3 & ~sda_q3 & sda_q2;

  // Slave state
  lmd_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [2:0] pointer;
  logic power_fail;
  logic [7:0] regs [0:REG_COUNT-1];

  // Address match
  wire [6:0] own_addr = SLAVE_ADDR_BASE + {5'h00, sel_q2};
  wire [6:0] rx_addr = shift_in[7:1];
  wire addr_match = (rx_addr == own_addr);
  wire addr_read = shift_in[0];
  wire in_ack = (bit_cnt == ACK_SLOT);
  wire ack_rise = scl_rise & in_ack;

  // Acknowledge decision for the slot that follows a received byte
  wire ack_addr = (state == ST_ADDR) & addr_match;
  wire ack_data = (state == ST_INSTR) | (state == ST_WDATA);
  wire give_ack = in_ack & (ack_addr | ack_data);

  // Read bit drive: low for a zero bit
  wire [2:0] out_idx = 3'h7 - bit_cnt[2:0];
  wire read_bit = shift_out[out_idx];
  wire read_low = (state == ST_RDATA) & ~in_ack & ~read_bit;
  wire next_sda_oe = give_ack | read_low;

  // Status byte
  wire [7:0] status_byte = 8'h00 | (8'(power_fail) << STATUS_FLAG_BIT);

  // Register write on the acknowledge clock of a data byte
  wire wr_en = ack_rise & (state == ST_WDATA);
  wire read_done = ack_rise & (state == ST_RDATA);
  // Flag already cleared for a byte that follows a finished read
  wire [7:0] next_shift_out = read_done ? 8'h00 : status_byte;

  // Next state and bit count
  lmd_state_e next_state;
  logic [3:0] next_bit_cnt;

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    if (bus_start) begin
      next_state = ST_ADDR;
      next_bit_cnt = 4'h0;
    end else if (bus_stop) begin
      next_state = ST_IDLE;
      next_bit_cnt = 4'h0;
    end else if (scl_rise && state != ST_IDLE && state != ST_IGNORE) begin
      if (!in_ack) begin
        next_bit_cnt = bit_cnt + 4'h1;
      end else begin
        next_bit_cnt = 4'h0;
        unique case (state)
          ST_ADDR: begin
            if (!addr_match) begin
              next_state = ST_IGNORE;
            end else if (addr_read) begin
              next_state = ST_RDATA;
            end else begin
              next_state = ST_INSTR;
            end
          end
          ST_INSTR: next_state = ST_WDATA;
          ST_WDATA: next_state = ST_WDATA;
          ST_RDATA: next_state = sda_q2 ? ST_IGNORE : ST_RDATA;
          default: next_state = ST_IGNORE;
        endcase
      end
    end
  end

  // Bit counter and state
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
    end
  end

  // Receive shift register
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      shift_in <= 8'h00;
    end else if (scl_rise && !in_ack) begin
      shift_in <= {shift_in[6:0], sda_q2};
    end
  end

  // Transmit byte reloaded at every acknowledge clock, address and data bytes alike
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      shift_out <= 8'h00;
    end else if (ack_rise) begin
      shift_out <= next_shift_out;
    end
  end

  // Subaddress pointer, stepping by one and wrapping from 7 to 0
  wire [2:0] next_pointer = pointer + 3'h1;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pointer <= SUB_CONTROL;
    end else if (ack_rise && state == ST_INSTR) begin
      pointer <= shift_in[2:0];
    end else if (wr_en) begin
      pointer <= next_pointer;
    end
  end

  // Power-fail flag: set only by reset, cleared by a finished read
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      power_fail <= FLAG_RESET;
    end else if (read_done) begin
      power_fail <= 1'b0;
    end
  end

  // Control and digit registers; subaddresses 5 to 7 store nothing
  wire [REG_COUNT-1:0] reg_wr;
  for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
    assign reg_wr[g] = wr_en & (pointer == 3'(g));
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        regs[g] <= REG_RESET;
      end else if (reg_wr[g]) begin
        regs[g] <= shift_in;
      end
    end
  end

  // SDA drive changes after SCL falls; a start or stop releases it while SCL is high
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
    end else if (bus_start || bus_stop) begin
      o_sda_oe <= 1'b0;
    end else if (scl_fall) begin
      o_sda_oe <= next_sda_oe;
    end
  end

  // Control fields
  lmd_ctrl_s ctrl;
  assign ctrl = lmd_ctrl_s'(regs[SUB_CONTROL]);

  // Multiplex oscillator, stopped in static mode
  logic mux_phase;
  wire osc_run = ctrl.mux_mode_bit;

  lmd_mux_timer #(
    .HALF_CYCLES(MUX_HALF)
  ) u_mux_timer (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_run(osc_run),
    .o_phase(mux_phase)
  );

  // Digit selection per bank
  wire second_pair = ctrl.mux_mode_bit & mux_phase;
  wire [7:0] low_digit = second_pair ? regs[SUB_DIGIT_THREE]
                                     : regs[SUB_DIGIT_ONE];
  wire [7:0] high_digit = second_pair ? regs[SUB_DIGIT_FOUR]
                                      : regs[SUB_DIGIT_TWO];
  wire [7:0] low_shown = ctrl.blank_pair_odd ? low_digit : 8'h00;
  wire [7:0] high_shown = ctrl.blank_pair_even ? high_digit : 8'h00;

  // Sink bank: data MSB to sink 8 or 16, LSB to sink 1 or 9
  wire [15:0] data_sinks;
  for (genvar b = 0; b < 8; b++) begin : g_sink
    assign data_sinks[b] = low_shown[b];
    assign data_sinks[b + 8] = high_shown[b];
  end
  wire [15:0] sinks = ctrl.segment_test_bit ? 16'hFFFF : data_sinks;

  // Drive bundle
  lmd_drive_s next_drive;
  assign next_drive.mux_drive_first = ~second_pair;
  assign next_drive.mux_drive_second = second_pair;
  assign next_drive.segments = sinks;

  // Current step enables: small, mid and large
  wire [2:0] current_bits = {ctrl.current_step_large, ctrl.current_step_mid,
                             ctrl.current_step_small};

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_segment_sink <= 16'h0000;
      o_mux_drive_first <= 1'b1;
      o_mux_drive_second <= 1'b0;
    end else begin
      o_segment_sink <= next_drive.segments;
      o_mux_drive_first <= next_drive.mux_drive_first;
      o_mux_drive_second <= next_drive.mux_drive_second;
    end
  end

  // Current and oscillator outputs
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_current_step <= 3'h0;
      o_mux_osc_run <= 1'b0;
    end else begin
      o_current_step <= current_bits;
      o_mux_osc_run <= osc_run;
    end
  end

endmodule

// >>> lmd_sva.sv
// Port checker of the LED driver slave
// Assumes binding onto lmd_led_driver
`timescale 1ns/1ns
module lmd_sva #(parameter int MUX_HALF = 4) (
  input wire logic i_core_clk, i_rstn, i_scl, i_sda, o_sda_out, o_sda_oe,
  input wire logic [1:0] i_addr_sel,
  input wire logic [15:0] o_segment_sink,
  input wire logic o_mux_drive_first, o_mux_drive_second, o_mux_osc_run,
  input wire logic [2:0] o_current_step
);
  localparam int HI = MUX_HALF + 2;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  property p_rst;
    $rose(i_rstn) |-> o_segment_sink == 16'h0 && o_current_step == 3'h0
      && !o_mux_osc_run && !o_sda_oe && o_mux_drive_first;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_static;
    (!o_mux_osc_run)[*2] |-> o_mux_drive_first && !o_mux_drive_second;
  endproperty
  a_static: assert property (p_static) else $error("static mux");
  property p_excl;
    o_mux_drive_first != o_mux_drive_second;
  endproperty
  a_excl: assert property (p_excl) else $error("mux overlap");
  property p_toggle;
    $rose(o_mux_drive_second) |-> ##[1:HI] $fell(o_mux_drive_second);
  endproperty
  a_toggle: assert property (p_toggle) else $error("mux stuck");
  property p_cur;
    $changed(o_current_step) |-> o_sda_oe;
  endproperty
  a_cur: assert property (p_cur) else $error("current off ack");
  property p_run;
    $changed(o_mux_osc_run) |-> o_sda_oe;
  endproperty
  a_run: assert property (p_run) else $error("mode off ack");
  property p_sink;
    !o_mux_osc_run && !$past(o_mux_osc_run) && $changed(o_segment_sink)
      |-> o_sda_oe;
  endproperty
  a_sink: assert property (p_sink) else $error("sinks off ack");
  property p_oe;
    $rose(o_sda_oe) |-> ##[1:300] !o_sda_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("data held low");
  property p_low;
    o_sda_oe |-> !o_sda_out;
  endproperty
  a_low: assert property (p_low) else $error("data not low");
  c_dyn: cover property ($rose(o_mux_drive_second));
  c_ack: cover property ($rose(o_sda_oe));
  c_test: cover property (o_segment_sink == 16'hffff);
endmodule
bind lmd_led_driver lmd_sva #(.MUX_HALF(MUX_HALF)) u_lmd_sva (.*);

// >>> lmd_bus_master.sv
// Two-wire bus master model
// Assumes SDA with pull-up resolved by the bench
`timescale 1ns/1ns
module lmd_bus_master (
  input wire logic i_core_clk,
  input wire logic i_sda_line,
  output logic o_scl,
  output logic o_sda
);
  int stretch = 0;
  initial o_scl = 1;
  initial o_sda = 1;
  task automatic q;
    repeat (2 + stretch) @(negedge i_core_clk);
  endtask
  task automatic bitx(input logic b, output logic v);
    o_scl = 0;
    q;
    o_sda = b;
    q;
    o_scl = 1;
    q;
    v = i_sda_line;
    q;
  endtask
  task automatic start;
    o_scl = 0;
    q;
    o_sda = 1;
    q;
    o_scl = 1;
    q;
    q;
    o_sda = 0;
    q;
  endtask
  task automatic stop;
    logic v;
    bitx(0, v);
    o_sda = 1;
    q;
  endtask
  task automatic xfer(input logic [7:0] d, input logic m9,
    output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r[i]);
    bitx(m9, a);
  endtask
endmodule

// >>> lmd_led_driver_tb.sv
// Self-checking bench of the LED driver slave
// Assumes the bus master model and the bound checker
`timescale 1ns/1ns
module lmd_led_driver_tb;
  import lmd_pkg::*;
  logic i_core_clk = 0;
  logic i_rstn = 0;
  logic [1:0] i_addr_sel = 0;
  logic o_sda_out, o_sda_oe, o_mux_drive_first, o_mux_drive_second;
  logic o_mux_osc_run;
  logic [15:0] o_segment_sink;
  logic [2:0] o_current_step;
  logic scl, msda;
  wire sda_line = msda & ~(o_sda_oe & ~o_sda_out);
  logic [7:0] regs [5] = '{default: 8'h0};
  logic flag = 1;
  int ptr, fail_count, samples_checked, seed = 31362;
  always #10 i_core_clk = ~i_core_clk;
  lmd_led_driver #(.MUX_HALF(4)) u_lmd_led_driver (.i_core_clk(i_core_clk),
    .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda_line), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .i_addr_sel(i_addr_sel),
    .o_segment_sink(o_segment_sink), .o_mux_drive_first(o_mux_drive_first),
    .o_mux_drive_second(o_mux_drive_second),
    .o_current_step(o_current_step), .o_mux_osc_run(o_mux_osc_run));
  lmd_bus_master u_lmd_bus_master (.i_core_clk(i_core_clk),
    .i_sda_line(sda_line), .o_scl(scl), .o_sda(msda));
  task automatic tally(input logic ok, input string s);
    samples_checked++;
    if (!ok) begin
      fail_count++;
      $display("mismatch %0t %s", $time, s);
    end
  endtask
  task automatic chk_bus(input logic [7:0] got, exp);
    tally(got === exp, "bus byte");
  endtask
  task automatic chk_pins(input logic [21:0] got, exp);
    tally(got === exp, "display pins");
  endtask
  function automatic logic [21:0] exp_pins(input logic ph);
    logic [7:0] c;
    logic [15:0] s;
    c = regs[0];
    s = ph ? {regs[4], regs[3]} : {regs[2], regs[1]};
    if (!c[1]) s[7:0] = 8'h0;
    if (!c[2]) s[15:8] = 8'h0;
    if (c[3]) s = 16'hffff;
    return {c[6:4], c[0], !ph, ph, s};
  endfunction
  task automatic check_disp;
    repeat (12) begin
      @(negedge i_core_clk);
      chk_pins({o_current_step, o_mux_osc_run, o_mux_drive_first,
        o_mux_drive_second, o_segment_sink},
        exp_pins(regs[0][0] & o_mux_drive_second));
    end
  endtask
  task automatic probe(input logic [7:0] ad, input logic line);
    logic a;
    logic [7:0] r;
    u_lmd_bus_master.start();
    u_lmd_bus_master.xfer(ad, 1, r, a);
    chk_bus({7'h0, a}, {7'h0, line});
    u_lmd_bus_master.stop();
  endtask
  task automatic wr(input logic [2:0] p, input int n);
    logic a;
    logic [7:0] d, r;
    u_lmd_bus_master.start();
    u_lmd_bus_master.xfer({4'h7, 1'b0, i_addr_sel, 1'b0}, 1, r, a);
    u_lmd_bus_master.xfer({5'h0, p}, 1, r, a);
    ptr = p;
    repeat (n) begin
      d = 8'($random(seed));
      u_lmd_bus_master.xfer(d, 1, r, a);
      chk_bus({7'h0, a}, 8'h0);
      if (ptr < 5) regs[ptr] = d;
      ptr = (ptr + 1) % 8;
    end
    u_lmd_bus_master.stop();
  endtask
  task automatic rd(input int n);
    logic a;
    logic [7:0] r;
    u_lmd_bus_master.start();
    u_lmd_bus_master.xfer({4'h7, 1'b0, i_addr_sel, 1'b1}, 1, r, a);
    for (int j = 0; j < n; j++) begin
      u_lmd_bus_master.xfer(8'hff, j == n - 1, r, a);
      chk_bus(r, {flag, 7'h0});
      flag = 0;
    end
    u_lmd_bus_master.stop();
  endtask
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge i_core_clk);
    fail_count++;
    end_sim;
  end
  initial begin
    repeat (20) @(negedge i_core_clk);
    i_rstn = 1;
    repeat (4) @(negedge i_core_clk);
    check_disp;
    rd(2);
    rd(1);
    $display("status test done");
    for (int s = 0; s < 4; s++) begin
      i_addr_sel = 2'(s);
      probe({4'h7, 1'b0, i_addr_sel, 1'b0}, 0);
      probe({4'h7, 1'b0, i_addr_sel + 2'h1, 1'b0}, 1);
      probe({1'b1, 7'($random(seed))}, 1);
    end
    $display("address test done");
    for (int k = 0; k < 10; k++) begin
      u_lmd_bus_master.stretch = k % 3;
      wr(3'($random(seed)), 2 + k);
      check_disp;
    end
    rd(1);
    $display("display test done");
    i_rstn = 0;
    repeat (20) @(negedge i_core_clk);
    i_rstn = 1;
    regs = '{default: 8'h0};
    flag = 1;
    repeat (4) @(negedge i_core_clk);
    check_disp;
    rd(1);
    $display("reset test done");
    end_sim;
  end
endmodule
